// >>> design/weak_infeed_map.svh
`ifndef WEAK_INFEED_MAP_SVH
`define WEAK_INFEED_MAP_SVH
// Clock and tick
`define CLK_HZ 250000000
`define TICK_MS_HZ 1000
`define TICK_DIV ((`CLK_HZ / `TICK_MS_HZ) - 1)
`define TICK_DIV_W 18
// Setting widths (milliseconds, 0..30000)
`define MS_W 15
`define MS_MAX 15'h7530
// Defaults in milliseconds
`define REC_EXT_MS 15'h028a
`define RES_EXT_MS 15'h0258
`define RES_ALARM_MS 15'h2710
`define SP_DELAY_MS 15'h0190
`define MP_DELAY_MS 15'h03e8
`define RES_TRIP_MS 15'h01f4
// Voltage and current words
`define V_W 16
`define I_W 16
// Factor in hundredths, 10..100, default 70
`define FACT_W 7
`define FACT_DEF 7'h46
`define FACT_SCALE 100
// Threshold tracking: shift per tick from tau seconds
`define TAU_W 6
`define TAU_DEF 6'h05
`define TRACK_SH 10
// Residual threshold in mA
`define RES_THR_1A 16'h01f4
`define RES_THR_5A 16'h09c4
`endif

// >>> design/weak_infeed_pkg.sv
package weak_infeed_pkg;
    typedef enum logic [1:0] {
        FUNC_OFF = 2'h0,
        FUNC_ECHO_ONLY = 2'h1,
        FUNC_ECHO_TRIP = 2'h2
    } function_mode_e;
    typedef enum logic {
        DELAYED_ON = 1'h0,
        DELAYED_BY_RX_FAIL = 1'h1
    } delayed_mode_e;
endpackage

// >>> design/weak_infeed_trip_logic.sv
`timescale 1ns/1ps
`include "weak_infeed_map.svh"
// Behaviour
// RQ1 - Instant trip per phase on extended receive plus phase undervoltage
// RQ2 - Other picked-up protection blocks the affected phases
// RQ3 - Receive signal stretched by settable extension time
// RQ4 - Inverse-time overcurrent pickup latches phase against further pickup
// RQ5 - Receive, no undervoltage, residual over 500 ms gives three-pole trip
// RQ6 - Residual exceeded flag extended by settable time
// RQ7 - Residual alarm after residual stays high past alarm delay
// RQ8 - Residual threshold settable, default depends on transformer rating
// RQ9 - Instant stage works only while channel reports OK
// RQ10 - Per-phase block inputs inhibit instant stage for those phases
// RQ11 - Instant stage mode ON or OFF enables the instant stage
// RQ12 - Single-pole allow gives single-pole delayed trips
// RQ13 - Single-pole delayed trip may require residual exceeded
// RQ14 - Three-pole allow turns multi-phase pickup into three-pole trip
// RQ15 - Delayed stage picks up on undervoltage, trips after its delay
// RQ16 - Delayed stage mode ON or active only on channel failure
// RQ17 - Voltage failure blocks undervoltage phase selection entirely
// RQ18 - Undervoltage threshold is factor times phase-phase voltage
// RQ19 - Threshold tracks voltage through a slow first-order delay
// RQ20 - Phase below open-pole voltage is not reported undervoltage
// RQ21 - Shared-channel echo setting provided, default NO
// RQ22 - Function mode OFF, echo only or echo and trip
// RQ23 - Delayed stage block input inhibits delayed stage
// RQ24 - Separate per-phase single-pole trip outputs plus general trip
// RQ25 - All delays are counters of a common millisecond tick
// RQ26 - Function mode OFF or echo only suppresses all trip outputs
module weak_infeed_trip_logic
    import weak_infeed_pkg::*;
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic weak_feed_receive_in,
    input wire logic channel_ok_input_in,
    input wire logic [2:0] other_pickup_in,
    input wire logic [2:0] inverse_oc_pickup_in,
    input wire logic [2:0] phase_block_in,
    input wire logic delayed_stage_block_in,
    input wire logic voltage_failure_in,
    input wire logic [`V_W-1:0] phase_voltage_in [3],
    input wire logic [`V_W-1:0] phase_phase_voltage_in,
    input wire logic [`V_W-1:0] open_pole_voltage_in,
    input wire logic [`I_W-1:0] residual_current_in,
    input wire logic ct_5a_in,
    input wire logic [`FACT_W-1:0] undervoltage_factor_in,
    input wire logic [`TAU_W-1:0] tau_seconds_in,
    input wire logic [`MS_W-1:0] receive_extension_in,
    input wire logic [`MS_W-1:0] residual_flag_extension_in,
    input wire logic [`MS_W-1:0] residual_alarm_delay_in,
    input wire logic [`MS_W-1:0] single_pole_delay_in,
    input wire logic [`MS_W-1:0] multi_pole_delay_in,
    input wire logic [`I_W-1:0] residual_threshold_setting_in,
    input wire logic residual_threshold_default_in,
    input wire logic single_pole_allow_in,
    input wire logic single_pole_needs_residual_in,
    input wire logic three_pole_allow_in,
    input wire logic instant_stage_mode_in,
    input wire logic delayed_stage_mode_in,
    input wire logic shared_channel_echo_in,
    input wire logic [1:0] function_mode_in,
    output logic [2:0] undervoltage_out,
    output logic [2:0] instant_trip_out,
    output logic [2:0] single_pole_trip_out,
    output logic three_pole_trip_out,
    output logic residual_trip_out,
    output logic general_trip_out,
    output logic multi_pickup_out,
    output logic residual_alarm_out,
    output logic echo_single_channel_out
);
    logic rst_meta, rst_sync;
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Pin synchronisers: three stages, accept when last two agree
    localparam int NSYNC = 13;
    logic [NSYNC-1:0] pin_raw, s1, s2, s3, pin;
    assign pin_raw = {weak_feed_receive_in, channel_ok_input_in,
                      other_pickup_in, inverse_oc_pickup_in, phase_block_in,
                      delayed_stage_block_in, voltage_failure_in};
    always_ff @(posedge mclk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            pin <= '0;
        end else begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
            for (int k = 0; k < NSYNC; k++) begin
                if (s2[k] == s3[k]) begin
                    pin[k] <= s3[k];
                end
            end
        end
    end
    logic rx, ch_ok, dly_blk, vfail;
    logic [2:0] other_pu, inv_oc, ph_blk;
    assign rx = pin[12];
    assign ch_ok = pin[11];
    assign other_pu = pin[10:8];
    assign inv_oc = pin[7:5];
    assign ph_blk = pin[4:2];
    assign dly_blk = pin[1];
    assign vfail = pin[0];

    // Common millisecond tick
    logic [`TICK_DIV_W-1:0] div_cnt;
    logic tick;
    always_ff @(posedge mclk_in or negedge rst_sync) begin // RQ25
        if (!rst_sync) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else if (div_cnt == `TICK_DIV_W'(`TICK_DIV)) begin
            div_cnt <= '0;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    function automatic logic [`MS_W-1:0] clamp_ms(input logic [`MS_W-1:0] v);
        clamp_ms = (v > `MS_MAX) ? `MS_MAX : v;
    endfunction

    // Slowly tracking reference of phase-phase voltage
    logic [`V_W+`TRACK_SH-1:0] track_acc;
    logic [`V_W-1:0] track_v;
    logic [`V_W+`TRACK_SH-1:0] track_in_ext;
    logic [`V_W+`TRACK_SH-1:0] track_step_up, track_step_dn;
    logic [`TAU_W-1:0] tau_eff;
    assign tau_eff = (tau_seconds_in == '0) ? `TAU_DEF : tau_seconds_in;
    assign track_v = track_acc[`V_W+`TRACK_SH-1:`TRACK_SH];
    assign track_in_ext = {phase_phase_voltage_in, `TRACK_SH'(0)};
    assign track_step_up = (track_in_ext - track_acc) / tau_eff;
    assign track_step_dn = (track_acc - track_in_ext) / tau_eff;
    logic track_loaded;
    always_ff @(posedge mclk_in or negedge rst_sync) begin // RQ19
        if (!rst_sync) begin
            track_acc <= '0;
            track_loaded <= 1'b0;
        end else if (!track_loaded) begin
            // Seed from the present voltage, not from zero
            track_acc <= track_in_ext;
            track_loaded <= 1'b1;
        end else if (tick) begin
            if (track_in_ext > track_acc) begin
                track_acc <= track_acc + (track_step_up >> `TRACK_SH);
            end else begin
                track_acc <= track_acc - (track_step_dn >> `TRACK_SH);
            end
        end
    end

    // Undervoltage per phase
    logic [`FACT_W-1:0] fact;
    logic [`V_W+`FACT_W-1:0] thr_prod;
    logic [`V_W-1:0] uv_thr;
    logic [2:0] uv;
    assign fact = (undervoltage_factor_in == '0) ? `FACT_DEF
                                                 : undervoltage_factor_in;
    assign thr_prod = track_v * fact;
    assign uv_thr = `V_W'(thr_prod / `FACT_SCALE); // RQ18
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_uv
            assign uv[g] = !vfail // RQ17
                && (phase_voltage_in[g] < uv_thr)
                && (phase_voltage_in[g] >= open_pole_voltage_in); // RQ20
        end
    endgenerate

    // Residual current detection
    logic [`I_W-1:0] res_thr;
    logic res_over;
    assign res_thr = residual_threshold_default_in
        ? (ct_5a_in ? `RES_THR_5A : `RES_THR_1A)
        : residual_threshold_setting_in; // RQ8
    assign res_over = residual_current_in > res_thr;

    // Timers
    logic [`MS_W-1:0] rx_cnt, res_ext_cnt, res_alm_cnt, res_trip_cnt;
    logic rx_ext, res_flag;
    assign rx_ext = rx || (rx_cnt != '0); // RQ3
    assign res_flag = res_over || (res_ext_cnt != '0); // RQ6
    always_ff @(posedge mclk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            rx_cnt <= '0;
            res_ext_cnt <= '0;
        end else begin
            if (rx) begin
                rx_cnt <= clamp_ms(receive_extension_in); // RQ3
            end else if (tick && rx_cnt != '0) begin
                rx_cnt <= rx_cnt - 1'b1;
            end
            if (res_over) begin
                res_ext_cnt <= clamp_ms(residual_flag_extension_in); // RQ6
            end else if (tick && res_ext_cnt != '0) begin
                res_ext_cnt <= res_ext_cnt - 1'b1;
            end
        end
    end
    always_ff @(posedge mclk_in or negedge rst_sync) begin // RQ7
        if (!rst_sync) begin
            res_alm_cnt <= '0;
            residual_alarm_out <= 1'b0;
        end else if (!res_over) begin
            res_alm_cnt <= '0;
            residual_alarm_out <= 1'b0;
        end else begin
            if (res_alm_cnt >= clamp_ms(residual_alarm_delay_in)) begin
                residual_alarm_out <= 1'b1;
            end else if (tick) begin
                res_alm_cnt <= res_alm_cnt + 1'b1;
            end
        end
    end

    // Latch against pickup after inverse-time overcurrent
    logic [2:0] oc_latch;
    always_ff @(posedge mclk_in or negedge rst_sync) begin // RQ4
        if (!rst_sync) begin
            oc_latch <= '0;
        end else begin
            oc_latch <= oc_latch | inv_oc;
        end
    end

    logic trip_en;
    assign trip_en = (function_mode_in == FUNC_ECHO_TRIP); // RQ26
    logic [2:0] ph_ok, inst, dly_pu;
    assign ph_ok = ~other_pu & ~oc_latch; // RQ2
    assign inst = {3{rx_ext && ch_ok && instant_stage_mode_in}} // RQ9
        & uv & ph_ok & ~ph_blk; // RQ1 RQ10

    // Residual-only three-pole path
    logic res_cond;
    assign res_cond = rx_ext && (uv == 3'h0) && res_flag && trip_en;
    always_ff @(posedge mclk_in or negedge rst_sync) begin // RQ5
        if (!rst_sync) begin
            res_trip_cnt <= '0;
        end else if (!res_cond) begin
            res_trip_cnt <= '0;
        end else if (tick && res_trip_cnt <= `RES_TRIP_MS) begin
            res_trip_cnt <= res_trip_cnt + 1'b1;
        end
    end

    // Delayed stage
    logic dly_active, multi;
    logic [`MS_W-1:0] dly_cnt;
    assign dly_active = !dly_blk // RQ23
        && ((delayed_stage_mode_in == DELAYED_ON) || !ch_ok); // RQ16
    assign dly_pu = {3{dly_active}} & uv & ph_ok; // RQ15
    assign multi = (dly_pu[0] + dly_pu[1] + dly_pu[2]) > 2'h1;
    always_ff @(posedge mclk_in or negedge rst_sync) begin // RQ25
        if (!rst_sync) begin
            dly_cnt <= '0;
        end else if (dly_pu == 3'h0) begin
            dly_cnt <= '0;
        end else if (tick && dly_cnt != `MS_MAX) begin
            dly_cnt <= dly_cnt + 1'b1;
        end
    end
    logic sp_due, mp_due;
    assign sp_due = !multi && dly_pu != 3'h0
        && dly_cnt >= clamp_ms(single_pole_delay_in)
        && single_pole_allow_in // RQ12
        && (!single_pole_needs_residual_in || res_flag); // RQ13
    assign mp_due = multi && dly_cnt >= clamp_ms(multi_pole_delay_in)
        && three_pole_allow_in; // RQ14

    // Registered outputs
    always_ff @(posedge mclk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            undervoltage_out <= '0;
            instant_trip_out <= '0;
            single_pole_trip_out <= '0;
            three_pole_trip_out <= 1'b0;
            residual_trip_out <= 1'b0;
            general_trip_out <= 1'b0;
            multi_pickup_out <= 1'b0;
            echo_single_channel_out <= 1'b0;
        end else begin
            undervoltage_out <= uv;
            multi_pickup_out <= multi;
            echo_single_channel_out <= shared_channel_echo_in; // RQ21
            instant_trip_out <= trip_en ? inst : 3'h0; // RQ11
            single_pole_trip_out <=
                (trip_en && sp_due) ? dly_pu : 3'h0; // RQ24
            residual_trip_out <= res_trip_cnt > `RES_TRIP_MS; // RQ5
            three_pole_trip_out <= trip_en
                && (mp_due || res_trip_cnt > `RES_TRIP_MS);
            general_trip_out <= trip_en && ((inst != 3'h0) || sp_due
                || mp_due || res_trip_cnt > `RES_TRIP_MS); // RQ22
        end
    end
endmodule

// >>> sim/remote_relay_model.sv
`timescale 1ns/1ps
module remote_relay_model (
    input wire logic clk_in,
    input wire logic send_in,
    input wire logic fail_in,
    output logic receive_out,
    output logic channel_ok_out
);
    // Failed channel reports not OK and carries no receive signal
    always_ff @(posedge clk_in) begin
        channel_ok_out <= !fail_in;
        receive_out <= send_in && !fail_in;
    end
endmodule

// >>> sim/weak_infeed_trip_logic_chk.sv
`timescale 1ns/1ps
module weak_infeed_trip_logic_chk (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic channel_ok_input_in,
    input wire logic voltage_failure_in,
    input wire logic instant_stage_mode_in,
    input wire logic shared_channel_echo_in,
    input wire logic [2:0] other_pickup_in,
    input wire logic [2:0] phase_block_in,
    input wire logic [1:0] function_mode_in,
    input wire logic [2:0] undervoltage_out,
    input wire logic [2:0] instant_trip_out,
    input wire logic [2:0] single_pole_trip_out,
    input wire logic three_pole_trip_out,
    input wire logic general_trip_out,
    input wire logic echo_single_channel_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    property p_trip_off;
        (function_mode_in != 2'h2) [*8] |-> !general_trip_out
            && !three_pole_trip_out
            && (instant_trip_out | single_pole_trip_out) == 3'h0;
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("off trip");
    property p_vfail;
        voltage_failure_in [*8] |-> undervoltage_out == 3'h0;
    endproperty
    a_vfail: assert property (p_vfail) else $error("uv on vfail");
    property p_chan;
        !channel_ok_input_in [*8] |-> instant_trip_out == 3'h0;
    endproperty
    a_chan: assert property (p_chan) else $error("trip on bad channel");
    property p_block;
        phase_block_in[0] [*8] |-> !instant_trip_out[0];
    endproperty
    a_block: assert property (p_block) else $error("blocked trip");
    property p_mode;
        !instant_stage_mode_in [*8] |-> instant_trip_out == 3'h0;
    endproperty
    a_mode: assert property (p_mode) else $error("instant stage off");
    property p_other;
        other_pickup_in[1] [*8]
            |-> !instant_trip_out[1] && !single_pole_trip_out[1];
    endproperty
    a_other: assert property (p_other) else $error("trip on pickup");
    property p_uv;
        $rose(instant_trip_out[0])
            |-> undervoltage_out[0] || $past(undervoltage_out[0]);
    endproperty
    a_uv: assert property (p_uv) else $error("trip without uv");
    property p_gen;
        $rose(|instant_trip_out) |-> ##[0:2] general_trip_out;
    endproperty
    a_gen: assert property (p_gen) else $error("general trip missing");
    property p_echo;
        shared_channel_echo_in [*8] |-> echo_single_channel_out;
    endproperty
    a_echo: assert property (p_echo) else $error("echo setting lost");
endmodule
bind weak_infeed_trip_logic weak_infeed_trip_logic_chk chk (.*);

// >>> sim/tb_weak_infeed_trip_logic.sv
`timescale 1ns/1ps
module tb_weak_infeed_trip_logic;
    logic mclk_in = 1'b0, nrst_in = 1'b0, send = 1'b0, fail = 1'b0;
    wire logic weak_feed_receive_in, channel_ok_input_in;
    logic [2:0] other_pickup_in = 3'h0, inverse_oc_pickup_in = 3'h0;
    logic [2:0] phase_block_in = 3'h0;
    logic delayed_stage_block_in = 1'b0, voltage_failure_in = 1'b0;
    logic [15:0] phase_voltage_in [3] = '{16'h0000, 16'h0000, 16'h0000};
    logic [15:0] phase_phase_voltage_in = 16'h4000;
    logic [15:0] open_pole_voltage_in = 16'h0000;
    logic [15:0] residual_current_in = 16'h0000;
    logic [15:0] residual_threshold_setting_in = 16'h01f4;
    logic ct_5a_in = 1'b0, residual_threshold_default_in = 1'b1;
    logic [6:0] undervoltage_factor_in = 7'h46;
    logic [5:0] tau_seconds_in = 6'h05;
    logic [14:0] receive_extension_in = 15'h0000;
    logic [14:0] residual_flag_extension_in = 15'h0000;
    logic [14:0] residual_alarm_delay_in = 15'h0000;
    logic [14:0] single_pole_delay_in = 15'h0000;
    logic [14:0] multi_pole_delay_in = 15'h0000;
    logic single_pole_allow_in = 1'b1, single_pole_needs_residual_in = 1'b1;
    logic three_pole_allow_in = 1'b1, instant_stage_mode_in = 1'b1;
    logic delayed_stage_mode_in = 1'b1, shared_channel_echo_in = 1'b0;
    logic [1:0] function_mode_in = 2'h2;
    logic [2:0] undervoltage_out, instant_trip_out, single_pole_trip_out;
    logic three_pole_trip_out, residual_trip_out, general_trip_out;
    logic multi_pickup_out, residual_alarm_out, echo_single_channel_out;
    int n_errors = 0, n_compared = 0;
    always #2 mclk_in = ~mclk_in;
    weak_infeed_trip_logic dut (.*);
    remote_relay_model far (.clk_in(mclk_in), .send_in(send), .fail_in(fail),
        .receive_out(weak_feed_receive_in),
        .channel_ok_out(channel_ok_input_in));
    task automatic chk(input string what, input logic [2:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle;
        repeat (10) @(posedge mclk_in);
        #1;
    endtask
    task automatic t_modes;
        send = 1'b1;
        for (int m = 0; m < 2; m++) begin
            function_mode_in = m[1:0];
            settle;
            chk("off", 3'h0, instant_trip_out | single_pole_trip_out);
            chk("general", 3'h0, {2'h0, general_trip_out});
            chk("three pole", 3'h0, {2'h0, three_pole_trip_out});
        end
        function_mode_in = 2'h2;
        settle;
        chk("undervoltage", 3'h7, undervoltage_out);
        chk("instant", 3'h7, instant_trip_out);
        chk("general", 3'h1, {2'h0, general_trip_out});
    endtask
    task automatic t_inhibit;
        for (int k = 0; k < 4; k++) begin
            fail = (k == 0);
            phase_block_in = (k == 1) ? 3'h7 : 3'h0;
            instant_stage_mode_in = (k != 2);
            other_pickup_in = (k == 3) ? 3'h7 : 3'h0;
            settle;
            chk("inhibited", 3'h0, instant_trip_out);
        end
        other_pickup_in = 3'h0;
    endtask
    task automatic t_voltage;
        voltage_failure_in = 1'b1;
        settle;
        chk("undervoltage", 3'h0, undervoltage_out);
        voltage_failure_in = 1'b0;
        open_pole_voltage_in = 16'h0100;
        settle;
        chk("undervoltage", 3'h0, undervoltage_out);
        open_pole_voltage_in = 16'h0000;
        shared_channel_echo_in = 1'b1;
        settle;
        chk("echo", 3'h1, {2'h0, echo_single_channel_out});
    endtask
    task automatic t_latch;
        inverse_oc_pickup_in = 3'h1;
        settle;
        inverse_oc_pickup_in = 3'h0;
        settle;
        chk("latched", 3'h6, instant_trip_out);
    endtask
    task automatic t_delayed;
        delayed_stage_mode_in = 1'b0;
        settle;
        chk("three pole", 3'h1, {2'h0, three_pole_trip_out});
        chk("multi", 3'h1, {2'h0, multi_pickup_out});
        three_pole_allow_in = 1'b0;
        settle;
        chk("three pole", 3'h0, {2'h0, three_pole_trip_out});
        chk("multi", 3'h1, {2'h0, multi_pickup_out});
        phase_voltage_in[1] = 16'h2e00;
        phase_voltage_in[2] = 16'h2e00;
        settle;
        chk("undervoltage", 3'h1, undervoltage_out);
        chk("single pole", 3'h0, single_pole_trip_out);
        residual_current_in = 16'h0258;
        settle;
        chk("single pole", 3'h1, single_pole_trip_out);
        chk("alarm", 3'h1, {2'h0, residual_alarm_out});
        ct_5a_in = 1'b1;
        settle;
        chk("single pole", 3'h0, single_pole_trip_out);
        chk("alarm", 3'h0, {2'h0, residual_alarm_out});
        ct_5a_in = 1'b0;
        delayed_stage_block_in = 1'b1;
        settle;
        chk("single pole", 3'h0, single_pole_trip_out);
        delayed_stage_block_in = 1'b0;
        delayed_stage_mode_in = 1'b1;
        settle;
        chk("single pole", 3'h0, single_pole_trip_out);
        fail = 1'b1;
        settle;
        chk("single pole", 3'h1, single_pole_trip_out);
        single_pole_allow_in = 1'b0;
        settle;
        chk("single pole", 3'h0, single_pole_trip_out);
        single_pole_allow_in = 1'b1;
        fail = 1'b0;
        phase_voltage_in[0] = 16'h2e00;
        settle;
        chk("residual", 3'h0, {2'h0, residual_trip_out});
        phase_voltage_in[2] = 16'h2c00;
        settle;
        chk("undervoltage", 3'h4, undervoltage_out);
        phase_voltage_in = '{16'h0000, 16'h0000, 16'h0000};
        residual_current_in = 16'h0000;
        three_pole_allow_in = 1'b1;
        settle;
    endtask
    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        give_verdict;
    end
    initial begin
        repeat (3) @(posedge mclk_in);
        #1;
        nrst_in = 1'b1;
        settle;
        t_modes;
        t_inhibit;
        t_voltage;
        t_delayed;
        t_latch;
        give_verdict;
    end
endmodule
